// ===== rtl/spicl_defs.svh
// Constants of the serial port control block: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef SPICL_DEFS_SVH
`define SPICL_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPICL_OFS_CTRL     5'h00
`define SPICL_OFS_TXDATA   5'h04
`define SPICL_OFS_RXDATA   5'h08
`define SPICL_OFS_IRQSTAT  5'h0c
`define SPICL_OFS_IRQMASK  5'h10
`define SPICL_OFS_DIVIDER  5'h14

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define SPICL_CTRL_W       11
`define SPICL_IRQ_W        3
`define SPICL_IRQ_TXEMPTY  0
`define SPICL_IRQ_RXFULL   1
`define SPICL_IRQ_OVERFLOW 2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SPICL_CTRL_RST     11'h000
`define SPICL_MASK_RST     3'h0
`define SPICL_DIV_RST      8'h03
`define SPICL_LAST_HALF    4'hf
`define SPICL_LAST_BIT     3'h7
`define SPICL_FILL_BYTE    8'h00

`endif

// ===== rtl/spicl_pkg.sv
// Types shared by the serial port control block.
// Assumes nothing of its surroundings.
package spicl_pkg;

  // Low eleven bits of serial_port_control, bit 10 first
  typedef struct packed {
    logic loopback_select;
    logic slave_out_drive_enable;
    logic rx_overflow_overwrite;
    logic underrun_zero_fill;
    logic transfer_trigger_mode;
    logic lsb_first_select;
    logic wired_or_output;
    logic clock_idle_polarity;
    logic clock_phase_select;
    logic master_select;
    logic port_enable;
  } spicl_ctrl_t;

  typedef enum logic {
    SPICL_IDLE,
    SPICL_RUN
  } spicl_state_t;

endpackage : spicl_pkg

// ===== rtl/spicl_core.sv
// Serial port with Avalon-MM register slave, master and slave engines.
// Assumes pins reach it raw: the interface or bench resolves the wires
// from the output enables; all pin inputs are synchronised here.
//
// Functional notes
// (R1) Loopback routes serial output to serial input
// (R2) Slave out enable clear makes output open-drain
// (R3) Overflow: overwrite bit replaces, else drops byte
// (R4) Empty transmit: send zero or repeat last
// (R5) Trigger mode set: write starts, empty irq
// (R6) Trigger mode clear: read starts, full irq
// (R7) Bit order select: LSB or MSB first
// (R8) Wired-OR: data outputs drive only low
// (R9) Polarity bit sets clock idle level
// (R10) Phase bit: pulse at start or end
// (R11) Master select: generate clock and select, else slave
// (R12) Port disabled means no transfers
// (R13) Each transfer moves exactly eight bits
// (R14) Mode changes apply only between transfers; clearing port enable stops a running transfer at once; rx_overflow_overwrite is read live
`timescale 1ns/100ps
`include "spicl_defs.svh"

module spicl_core (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_out,
  input  wire logic        cs_n_in,
  output logic             cs_n_out,
  output logic             cs_n_oe_out,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [7:0] rx_shift(input logic [7:0] sh,
                                          input logic       bit_in,
                                          input logic       lsb_first);
    return lsb_first ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
  endfunction : rx_shift

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  spicl_pkg::spicl_ctrl_t ctrl_q;
  spicl_pkg::spicl_ctrl_t cfg_q;
  spicl_pkg::spicl_state_t state_q;
  logic [`SPICL_IRQ_W-1:0] stat_q;
  logic [`SPICL_IRQ_W-1:0] mask_q;
  logic [7:0]  div_q;
  logic [7:0]  txbuf_q;
  logic        txvalid_q;
  logic [7:0]  last_tx_q;
  logic [7:0]  rxdata_q;
  logic        rxvalid_q;
  logic        rd_start_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------------
  wire req      = avs_read_in | avs_write_in;
  wire wr_fire  = avs_write_in & ack_q;
  wire rd_fire  = avs_read_in & ack_q;
  wire sel_ctrl = avs_address_in == `SPICL_OFS_CTRL;
  wire sel_tx   = avs_address_in == `SPICL_OFS_TXDATA;
  wire sel_rx   = avs_address_in == `SPICL_OFS_RXDATA;
  wire sel_stat = avs_address_in == `SPICL_OFS_IRQSTAT;
  wire sel_mask = avs_address_in == `SPICL_OFS_IRQMASK;
  wire sel_div  = avs_address_in == `SPICL_OFS_DIVIDER;
  wire wr_tx    = wr_fire & sel_tx & avs_byteenable_in[0] & ctrl_q.port_enable;
  wire rd_rx    = rd_fire & sel_rx;
  wire [31:0] ctrl_word = {21'h000000, ctrl_q};
  wire [31:0] ctrl_new  = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
  wire [31:0] mask_new  = be_merge({29'h00000000, mask_q}, avs_writedata_in,
                                   avs_byteenable_in);
  wire [31:0] div_new   = be_merge({24'h000000, div_q}, avs_writedata_in,
                                   avs_byteenable_in);
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_word :
    sel_rx   ? {24'h000000, rxdata_q} :
    sel_stat ? {29'h00000000, stat_q} :
    sel_mask ? {29'h00000000, mask_q} :
    sel_div  ? {24'h000000, div_q} : 32'h00000000;

  assign avs_waitrequest_out = req & ~ack_q;
  assign avs_readdata_out    = rdata_q;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= req & ~ack_q;
      rdata_q <= (avs_read_in & ~ack_q) ? rd_mux : rdata_q;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers: sclk, cs_n, mosi, miso
  // ----------------------------------------------------------------------
  wire  [3:0] pin_raw = {sclk_in, cs_n_in, mosi_in, miso_in};
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       sclk_prev_q;
  logic       cs_prev_q;

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        sync1_q[g] <= 1'b1;
        sync2_q[g] <= 1'b1;
      end else begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  wire sclk_s = sync2_q[3];
  wire cs_n_s = sync2_q[2];
  wire mosi_s = sync2_q[1];
  wire miso_s = sync2_q[0];

  // ----------------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------------
  logic [7:0] txsh_q;
  logic [7:0] rxsh_q;
  logic [2:0] bcnt_q;
  logic [3:0] hc_q;
  logic [7:0] dcnt_q;
  logic       first_q;

  wire is_master  = cfg_q.master_select & ctrl_q.port_enable;              // R11 R12
  wire is_slave   = ~cfg_q.master_select & ctrl_q.port_enable;             // R11 R12
  wire slv_active = is_slave & ~cs_n_s;
  wire running    = state_q == spicl_pkg::SPICL_RUN;
  wire busy       = running | slv_active;
  wire out_bit    = cfg_q.lsb_first_select ? txsh_q[0] : txsh_q[7];        // R7
  wire [7:0] load_byte = txvalid_q ? txbuf_q :
                         (ctrl_q.underrun_zero_fill ? `SPICL_FILL_BYTE : last_tx_q); // R4
  // Loopback wraps the driven data straight back as received data
  wire rx_in = cfg_q.loopback_select ? out_bit :
               (cfg_q.master_select ? miso_s : mosi_s);                  // R1

  wire m_start = is_master & ~running &
                 (ctrl_q.transfer_trigger_mode ? txvalid_q : rd_start_q); // R5 R6
  wire tick    = running & (dcnt_q == 8'h00);
  wire m_sample = tick & ~hc_q[0];
  wire m_shift  = tick & hc_q[0];
  wire m_done   = tick & (hc_q == `SPICL_LAST_HALF);                      // R13

  wire s_edge  = slv_active & (sclk_s != sclk_prev_q);
  wire s_lead  = s_edge & (sclk_s != cfg_q.clock_idle_polarity);
  wire s_trail = s_edge & (sclk_s == cfg_q.clock_idle_polarity);
  wire s_sample = cfg_q.clock_phase_select ? s_trail : s_lead;            // R10
  wire s_shift  = (cfg_q.clock_phase_select ? s_lead : s_trail) & ~first_q;
  wire s_start  = is_slave & ~cs_n_s & cs_prev_q;
  wire s_done   = s_sample & (bcnt_q == `SPICL_LAST_BIT);                 // R13

  wire load    = m_start | s_start;
  wire sample  = m_sample | s_sample;
  wire shift   = m_shift | s_shift;
  wire done    = m_done | s_done;
  wire [7:0] rx_next = rx_shift(rxsh_q, rx_in, cfg_q.lsb_first_select);
  // Master done comes a half period after its eighth sample: no extra shift
  wire [7:0] rx_byte = m_done ? rxsh_q : rx_next;                         // R13

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= spicl_pkg::SPICL_IDLE;
      hc_q    <= 4'h0;
      dcnt_q  <= 8'h00;
    end else if (!is_master) begin
      state_q <= spicl_pkg::SPICL_IDLE;                                  // R12
    end else if (m_start) begin
      state_q <= spicl_pkg::SPICL_RUN;
      hc_q    <= 4'h0;
      dcnt_q  <= div_q;
    end else if (tick) begin
      state_q <= m_done ? spicl_pkg::SPICL_IDLE : state_q;
      hc_q    <= hc_q + 4'h1;
      dcnt_q  <= div_q;
    end else if (running) begin
      dcnt_q  <= dcnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      txsh_q  <= 8'h00;
      rxsh_q  <= 8'h00;
      bcnt_q  <= 3'h0;
      first_q <= 1'b0;
    end else if (load) begin
      txsh_q  <= load_byte;
      bcnt_q  <= 3'h0;
      first_q <= 1'b1;
    end else begin
      rxsh_q  <= sample ? rx_next : rxsh_q;
      bcnt_q  <= sample ? bcnt_q + 3'h1 : bcnt_q;
      first_q <= s_edge ? 1'b0 : first_q;
      if (shift) begin
        txsh_q <= cfg_q.lsb_first_select ? {1'b0, txsh_q[7:1]} : {txsh_q[6:0], 1'b0}; // R7
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  // ----------------------------------------------------------------------
  // Control, data and interrupt registers
  // ----------------------------------------------------------------------
  // A rx full flag set in the same cycle as a read stays set
  wire rx_keep   = rxvalid_q & ~rd_rx;
  wire overflow  = done & rx_keep;
  wire rx_store  = done & (~overflow | ctrl_q.rx_overflow_overwrite);     // R3
  wire [`SPICL_IRQ_W-1:0] irq_set = {
    overflow,
    done & ~cfg_q.transfer_trigger_mode,                                 // R6
    done & cfg_q.transfer_trigger_mode & ~txvalid_q & ~wr_tx};           // R5
  wire [`SPICL_IRQ_W-1:0] irq_clr =
    (wr_fire & sel_stat & avs_byteenable_in[0]) ? avs_writedata_in[2:0] : 3'h0;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `SPICL_CTRL_RST;
      cfg_q  <= `SPICL_CTRL_RST;
      mask_q <= `SPICL_MASK_RST;
      div_q  <= `SPICL_DIV_RST;
      stat_q <= 3'h0;
    end else begin
      ctrl_q <= (wr_fire & sel_ctrl) ? ctrl_new[`SPICL_CTRL_W-1:0] : ctrl_q;
      cfg_q  <= busy ? cfg_q : ctrl_q;                                    // R14
      mask_q <= (wr_fire & sel_mask) ? mask_new[2:0] : mask_q;
      div_q  <= (wr_fire & sel_div) ? div_new[7:0] : div_q;
      stat_q <= (stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      txbuf_q    <= 8'h00;
      txvalid_q  <= 1'b0;
      last_tx_q  <= 8'h00;
      rxdata_q   <= 8'h00;
      rxvalid_q  <= 1'b0;
      rd_start_q <= 1'b0;
    end else begin
      txbuf_q    <= wr_tx ? avs_writedata_in[7:0] : txbuf_q;
      txvalid_q  <= wr_tx | (txvalid_q & ~load);
      last_tx_q  <= load ? load_byte : last_tx_q;                         // R4
      rxdata_q   <= rx_store ? rx_byte : rxdata_q;
      rxvalid_q  <= done | rx_keep;
      rd_start_q <= (rd_rx & is_master & ~ctrl_q.transfer_trigger_mode) |
                    (rd_start_q & ~m_start & is_master);                  // R6
    end
  end

  assign irq_out = |(stat_q & mask_q);

  // ----------------------------------------------------------------------
  // Pin drivers, registered
  // ----------------------------------------------------------------------
  wire sclk_act  = cfg_q.clock_phase_select ? ~hc_q[0] : hc_q[0];         // R10
  wire sclk_d    = cfg_q.clock_idle_polarity ^ (running & sclk_act);      // R9
  wire m_drive   = running;
  wire s_drive   = slv_active;
  // Open-drain outputs only ever pull low; the pull-up gives the high
  wire mosi_od   = cfg_q.wired_or_output;                                 // R8
  wire miso_od   = cfg_q.wired_or_output | ~cfg_q.slave_out_drive_enable; // R2

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
      cs_n_out    <= 1'b1;
      cs_n_oe_out <= 1'b0;
      mosi_out    <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      sclk_out    <= sclk_d;
      sclk_oe_out <= is_master;                                           // R11
      cs_n_out    <= ~m_drive;
      cs_n_oe_out <= is_master;                                           // R11
      mosi_out    <= mosi_od ? 1'b0 : out_bit;
      mosi_oe_out <= m_drive & (~mosi_od | ~out_bit);                     // R8
      miso_out    <= miso_od ? 1'b0 : out_bit;
      miso_oe_out <= s_drive & (~miso_od | ~out_bit);                     // R2
    end
  end

endmodule : spicl_core

// ===== tb/spicl_core_asserts.sv
// Port checker for spicl_core, bound to every instance.
// Assumes the divider at its reset value and whole-word control writes.
`timescale 1ns/100ps

module spicl_core_asserts (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        sclk_out,
  input wire logic        sclk_oe_out,
  input wire logic        cs_n_out,
  input wire logic        mosi_out,
  input wire logic        mosi_oe_out
);
  logic [10:0]            ctl_q;
  logic [2:0]             age_q;
  logic [4:0]             tog_q;
  logic                   cs_n_q;
  logic                   sclk_q;
  spicl_pkg::spicl_ctrl_t cfg;
  wire                    rd_acc = avs_read_in && !avs_waitrequest_out;
  wire                    ctl_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 5'h00;
  assign cfg = ctl_q;

  // --------------------------------------------------------------
  // Shadow state: control word, its age, clock edges per frame
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_q  <= 11'h000;
      age_q  <= 3'h0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      tog_q  <= 5'h00;
    end else begin
      ctl_q  <= ctl_wr ? avs_writedata_in[10:0] : ctl_q;
      age_q  <= ctl_wr ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
      cs_n_q <= cs_n_out;
      sclk_q <= sclk_out;
      tog_q  <= (cs_n_out && cs_n_q) ? 5'h00 : tog_q + {4'h0, sclk_out != sclk_q};
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  wait_first_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("request accepted in its first cycle");
  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait cycle longer than one clock");
  rd_unmap_a: assert property (rd_acc && avs_address_in > 5'h14 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  ctrl_rb_a: assert property (rd_acc && avs_address_in == 5'h00 |-> avs_readdata_out == {21'h0, ctl_q})
    else $error("control readback differs from last write");
  clk_idle_a: assert property ((cs_n_out && sclk_oe_out)[*3] ##0 age_q == 3'h7 |-> sclk_out == cfg.clock_idle_polarity)
    else $error("serial clock idle level wrong");
  edge_count_a: assert property ($rose(cs_n_out) |=> tog_q == 5'd16)
    else $error("frame without sixteen clock edges");
  mosi_od_a: assert property (cfg.wired_or_output && mosi_oe_out && age_q > 3'h2 |-> !mosi_out)
    else $error("data driven high in wired-or mode");
  drv_en_a: assert property (age_q == 3'h7 |-> sclk_oe_out == (cfg.master_select && cfg.port_enable))
    else $error("clock driver state wrong for mode");
  en_off_a: assert property (!cfg.port_enable && age_q > 3'h2 |-> cs_n_out && !mosi_oe_out)
    else $error("activity while port disabled");
endmodule : spicl_core_asserts

bind spicl_core spicl_core_asserts u_spicl_core_asserts (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .cs_n_out(cs_n_out),
  .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out)
);

// ===== tb/spicl_peer.sv
// Behavioural serial slave: sends one set byte per frame, keeps the last.
// Assumes resolved pin levels and mode inputs set between frames.
`timescale 1ns/100ps

module spicl_peer (
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       mosi_in,
  input  wire logic       cpol_in,
  input  wire logic       cpha_in,
  input  wire logic       lsb_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  output logic [7:0]      rx_byte_out
);
  logic [7:0] sh_q;
  logic [7:0] acc_q;

  task automatic put_bit();
    miso_out = lsb_in ? sh_q[0] : sh_q[7];
    sh_q     = lsb_in ? sh_q >> 1 : sh_q << 1;
  endtask : put_bit

  initial begin
    miso_out    = 1'b0;
    miso_oe_out = 1'b0;
    rx_byte_out = 8'h00;
  end

  always @(negedge cs_n_in) begin
    sh_q        = tx_byte_in;
    miso_oe_out = 1'b1;
    if (!cpha_in) put_bit();
  end

  // Released line flips so a stale bit can never pass as data
  always @(posedge cs_n_in) begin
    miso_oe_out = 1'b0;
    miso_out    = ~miso_out;
    rx_byte_out = acc_q;
  end

  // Select and first clock edge may move together: let both settle first
  always @(sclk_in) begin
    #1;
    if (!cs_n_in && ((sclk_in != cpol_in) ^ cpha_in)) begin
      acc_q = lsb_in ? {mosi_in, acc_q[7:1]} : {acc_q[6:0], mosi_in};
    end else if (!cs_n_in) begin
      put_bit();
    end
  end
endmodule : spicl_peer

// ===== tb/spicl_core_tb.sv
// Self-checking bench: spicl_core as master against a serial slave model, then as slave against the bench link master.
// Assumes divider at reset value; pull-ups on select and data lines.
`timescale 1ns/100ps
`include "spicl_defs.svh"

`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h expected %h", $time, act, exp); end end

module spicl_core_tb;
  logic        clk, rst, rd_en, wr_en, waitreq, irq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [2:0]  md;
  logic [7:0]  peer_tx, peer_rx, txb, pb;
  logic        sclk_o, sclk_oe, cs_n_o, cs_n_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso, p_oe;
  logic        bm_sclk, bm_cs_n, bm_mosi;
  logic [7:0]  rcv;
  int          err_total, num_checks, odv;
  wire         sclk_w = sclk_oe ? sclk_o : bm_sclk;
  wire         cs_n_w = cs_n_oe ? cs_n_o : bm_cs_n;
  wire         mosi_w = mosi_oe ? mosi_o : bm_mosi;
  // Model slave answers only while the block is master
  wire         miso_w = miso_oe ? miso_o : (p_oe && sclk_oe ? p_miso : 1'b1);

  spicl_core u_spicl_core (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .irq_out(irq),
    .sclk_in(sclk_w), .sclk_out(sclk_o), .sclk_oe_out(sclk_oe), .cs_n_in(cs_n_w),
    .cs_n_out(cs_n_o), .cs_n_oe_out(cs_n_oe), .mosi_in(mosi_w), .mosi_out(mosi_o),
    .mosi_oe_out(mosi_oe), .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe));
  spicl_peer u_spicl_peer (
    .sclk_in(sclk_w), .cs_n_in(cs_n_w), .mosi_in(mosi_w), .cpol_in(md[0]), .cpha_in(md[1]),
    .lsb_in(md[2]), .tx_byte_in(peer_tx), .miso_out(p_miso), .miso_oe_out(p_oe),
    .rx_byte_out(peer_rx));

  // --------------------------------------------------------------
  // Bus access, status polling and verdict
  // --------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    addr  <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(negedge clk);
  endtask : bus

  task automatic wait_st(input int b);
    int n;
    n = 0;
    q = 32'h0;
    while (q[b] !== 1'b1 && n < 100) begin
      bus(1'b0, `SPICL_OFS_IRQSTAT, 32'h0);
      n++;
    end
    `CHK(q[b], 1'b1)
  endtask : wait_st

  // Link master for slave mode; serial clock period 125 ns
  task automatic link_xfer(input logic [7:0] b);
    logic [7:0] sh;
    sh  = b;
    odv = 0;
    if (!md[1]) begin
      bm_mosi <= md[2] ? sh[0] : sh[7];
      sh = md[2] ? sh >> 1 : sh << 1;
    end
    bm_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      #62.5;
      bm_sclk <= ~bm_sclk;
      if (i[0] == md[1]) begin
        rcv = md[2] ? {miso_w, rcv[7:1]} : {rcv[6:0], miso_w};
        if (miso_oe && miso_o) odv++;
      end else begin
        bm_mosi <= md[2] ? sh[0] : sh[7];
        sh = md[2] ? sh >> 1 : sh << 1;
      end
    end
    #62.5;
    bm_cs_n <= 1'b1;
    @(negedge clk);
  endtask : link_xfer

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    {rd_en, wr_en, addr, wdata, md, peer_tx} = '0;
    {bm_cs_n, bm_mosi, bm_sclk} = 3'b110;
    {err_total, num_checks} = 64'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 5'h18, 32'h7ff);
    bus(1'b0, `SPICL_OFS_CTRL, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, `SPICL_OFS_DIVIDER, 32'h0);
    `CHK(q[7:0], `SPICL_DIV_RST)
    bus(1'b0, 5'h18, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, `SPICL_OFS_IRQMASK, 32'h1);
    for (int m = 0; m < 8; m++) begin
      txb = 8'hc1 ^ {5'h0, m[2:0]};
      pb  = 8'h2d ^ {m[2:0], 5'h0};
      @(posedge clk);
      md      <= m[2:0];
      peer_tx <= pb;
      bus(1'b1, `SPICL_OFS_CTRL, 32'h43 | {26'h0, m[2], m == 7, m[0], m[1], 2'h0});
      bus(1'b1, `SPICL_OFS_TXDATA, {24'h0, txb});
      wait_st(`SPICL_IRQ_TXEMPTY);
      `CHK(irq, 1'b1)
      bus(1'b1, `SPICL_OFS_IRQSTAT, 32'h7);
      `CHK(irq, 1'b0)
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      `CHK(q[7:0], pb)
      `CHK(peer_rx, txb)
    end
    @(posedge clk);
    md <= 3'h0;
    for (int z = 0; z < 2; z++) begin
      bus(1'b1, `SPICL_OFS_CTRL, {24'h0, z[0], 7'h03});
      bus(1'b1, `SPICL_OFS_IRQSTAT, 32'h7);
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      wait_st(`SPICL_IRQ_RXFULL);
      `CHK(q[2:0], 3'b010)
      `CHK(irq, 1'b0)
      `CHK(peer_rx, z ? 8'h00 : 8'hc6)
    end
    bus(1'b1, `SPICL_OFS_IRQMASK, 32'h2);
    `CHK(irq, 1'b1)
    for (int o = 0; o < 2; o++) begin
      bus(1'b1, `SPICL_OFS_CTRL, {23'h0, o[0], 8'h43});
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      bus(1'b1, `SPICL_OFS_IRQSTAT, 32'h7);
      peer_tx = 8'h11;
      bus(1'b1, `SPICL_OFS_TXDATA, 32'h71);
      wait_st(`SPICL_IRQ_TXEMPTY);
      peer_tx = 8'h22;
      bus(1'b1, `SPICL_OFS_TXDATA, 32'h72);
      wait_st(`SPICL_IRQ_OVERFLOW);
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      `CHK(q[7:0], o ? 8'h22 : 8'h11)
    end
    bus(1'b1, `SPICL_OFS_CTRL, 32'h443);
    bus(1'b1, `SPICL_OFS_IRQSTAT, 32'h7);
    bus(1'b1, `SPICL_OFS_TXDATA, 32'h6e);
    wait_st(`SPICL_IRQ_TXEMPTY);
    bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
    `CHK(q[7:0], 8'h6e)
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      md      <= s ? 3'h4 : 3'h3;
      bm_sclk <= !s;
      bus(1'b1, `SPICL_OFS_CTRL, s ? 32'h021 : 32'h20d);
      bus(1'b1, `SPICL_OFS_IRQSTAT, 32'h7);
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      bus(1'b1, `SPICL_OFS_TXDATA, {24'h0, 7'h2d, s[0]});
      link_xfer({7'h49, s[0]});
      wait_st(`SPICL_IRQ_RXFULL);
      bus(1'b0, `SPICL_OFS_RXDATA, 32'h0);
      `CHK(q[7:0], {7'h49, s[0]})
      `CHK(rcv, {7'h2d, s[0]})
      `CHK(odv != 0, !s[0])
    end
    bus(1'b1, `SPICL_OFS_CTRL, 32'h042);
    report_and_stop();
  end
endmodule : spicl_core_tb
